// ### hw/fcx_fault_capture.sv
`timescale 1ns/100ps
// Functional notes
// RQ1: Mask bits 3:0 gate hardware-register reads
// RQ2: Bit 29 grants user thread-pointer reads
// RQ3: Enable resets zero; unimplemented bits read zero
// RQ4: Read-only fault address loads on address errors
// RQ5: Unaligned or user-to-kernel access raises address error
// RQ6: Translation variant also captures TLB fault addresses (code leaves it unchanged on EXC_TLB_RI and EXC_TLB_XI)
// RQ7: Bus errors leave fault address unchanged
// RQ8: Read-only instruction capture on listed exceptions
// RQ9: Asynchronous exceptions never touch instruction capture
// RQ10: No valid instruction word: capture undefined
// RQ11: Short instructions sit low, upper half zero
// RQ12: Config flag reports instruction capture present
// RQ13: One instruction capture per processor context
// RQ14: Denied user read raises reserved instruction
module fcx_fault_capture
  import fcx_pkg::*;
#(
  parameter int   CTX       = 2,
  parameter logic HAS_TLB   = 1'b1,
  parameter logic HAS_FINST = 1'b1,
  parameter int   AW        = (CTX > 1) ? $clog2(CTX) : 1
) (
  input  wire logic          REF_CLK,
  input  wire logic          RESET,
  input  wire logic [3:0]    REG_ADDR,
  input  wire logic [31:0]   REG_WDATA,
  input  wire logic          REG_WR,
  input  wire logic          REG_RD,
  output logic      [31:0]   REG_RDATA,
  input  wire fcx_access_s   ACCESS,
  output logic               ADDR_ERR,
  input  wire fcx_exc_s      EXC,
  input  wire logic [AW-1:0] EXC_CTX,
  input  wire fcx_hwr_s      HWR_REQ,
  output logic               HWR_ALLOW,
  output logic               HWR_RI,
  output logic [31:0]        HWENA,
  output logic               IRQ
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0]      hwena_r, hwena_nxt;
  logic [31:0]      fvaddr_r, fvaddr_nxt;
  logic [31:0]      tptr_r, tptr_nxt;
  logic [IRQ_W-1:0] stat_r, stat_nxt;
  logic [IRQ_W-1:0] mask_r, mask_nxt;
  logic [AW-1:0]    ctx_sel_r, ctx_sel_nxt;
  logic             addr_err_r, addr_err_nxt;
  logic [31:0]      rdata_r, rdata_nxt;
  logic             rd_fin_r, rd_fin_nxt;
  logic             wr_hit;
  logic             fin_we;
  logic [31:0]      fin_wdata;
  logic [31:0]      fin_rdata;
  logic [IRQ_W-1:0] events;
  logic             hwr_deny;

  // ----------------------------------------------------------------
  // Address error detection
  // ----------------------------------------------------------------
  always_comb begin
    addr_err_nxt = addr_fault(ACCESS); // RQ5
  end

  // ----------------------------------------------------------------
  // Instruction capture, one word per context
  // ----------------------------------------------------------------
  always_comb begin
    // Only synchronous causes with a real word write; else unchanged
    fin_we    = HAS_FINST && EXC.valid && sets_finstr(EXC.cause) && EXC.instr_valid; // RQ8 RQ9 RQ10
    fin_wdata = EXC.instr_short ? {HALF_ZERO, EXC.instr[15:0]} : EXC.instr; // RQ11
  end

  fcx_ctx_mem #(.CTX(CTX), .AW(AW)) fcx_ctx_mem_i ( // RQ13
    .clk   (REF_CLK),
    .we    (fin_we),
    .waddr (EXC_CTX),
    .wdata (fin_wdata),
    .raddr (ctx_sel_r),
    .rdata (fin_rdata)
  );

  fcx_hwr_gate fcx_hwr_gate_i (
    .clk   (REF_CLK),
    .rst   (RESET),
    .req   (HWR_REQ),
    .hwena (hwena_r),
    .allow (HWR_ALLOW),
    .deny  (hwr_deny)
  );

  // ----------------------------------------------------------------
  // Register writes and captures
  // ----------------------------------------------------------------
  always_comb begin
    wr_hit      = REG_WR;
    hwena_nxt   = hwena_r;
    fvaddr_nxt  = fvaddr_r;
    tptr_nxt    = tptr_r;
    mask_nxt    = mask_r;
    ctx_sel_nxt = ctx_sel_r;
    if (wr_hit) begin
      case (REG_ADDR)
        OFS_HWENA:    hwena_nxt = REG_WDATA & HWENA_IMPL; // RQ3
        OFS_TPTR:     tptr_nxt = REG_WDATA;
        OFS_IRQ_MASK: mask_nxt = REG_WDATA[IRQ_W-1:0];
        OFS_CTX_SEL:  ctx_sel_nxt = REG_WDATA[AW-1:0];
        default:      hwena_nxt = hwena_r;
      endcase
    end
    // Bus errors are not addressing faults, so the address holds
    if (EXC.valid && sets_fvaddr(EXC.cause, HAS_TLB)) begin
      fvaddr_nxt = EXC.vaddr; // RQ4 RQ6 RQ7
    end
    events = '0;
    events[IRQ_ADDR_ERR] = EXC.valid && ((EXC.cause == EXC_ADEL) || (EXC.cause == EXC_ADES));
    events[IRQ_TLB_ERR]  = EXC.valid && HAS_TLB && sets_fvaddr(EXC.cause, HAS_TLB)
                           && !events[IRQ_ADDR_ERR];
    events[IRQ_HWR_DENY] = hwr_deny;
    stat_nxt = stat_r;
    if (wr_hit && (REG_ADDR == OFS_IRQ_STAT)) begin
      stat_nxt = stat_r & ~REG_WDATA[IRQ_W-1:0];
    end
    // Set wins over a simultaneous clear
    stat_nxt = stat_nxt | events;
  end

  // ----------------------------------------------------------------
  // Read path: data in the cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt  = '0;
    rd_fin_nxt = 1'b0;
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_HWENA:    rdata_nxt = hwena_r & HWENA_IMPL; // RQ3
        OFS_FVADDR:   rdata_nxt = fvaddr_r;
        OFS_FINSTR:   rd_fin_nxt = HAS_FINST;
        OFS_CONFIG3:  rdata_nxt[CFG3_FWP_BIT] = HAS_FINST; // RQ12
        OFS_TPTR:     rdata_nxt = tptr_r;
        OFS_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = stat_r;
        OFS_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = mask_r;
        OFS_CTX_SEL:  rdata_nxt[AW-1:0] = ctx_sel_r;
        default:      rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      hwena_r    <= HWENA_RESET; // RQ3
      fvaddr_r   <= FAULT_RESET;
      tptr_r     <= TPTR_RESET;
      stat_r     <= '0;
      mask_r     <= '0;
      ctx_sel_r  <= '0;
      addr_err_r <= 1'b0;
      rdata_r    <= '0;
      rd_fin_r   <= 1'b0;
    end else begin
      hwena_r    <= hwena_nxt;
      fvaddr_r   <= fvaddr_nxt;
      tptr_r     <= tptr_nxt;
      stat_r     <= stat_nxt;
      mask_r     <= mask_nxt;
      ctx_sel_r  <= ctx_sel_nxt;
      addr_err_r <= addr_err_nxt;
      rdata_r    <= rdata_nxt;
      rd_fin_r   <= rd_fin_nxt;
    end
  end

  // Instruction word is read from the memory's own output register
  assign REG_RDATA = rd_fin_r ? fin_rdata : rdata_r;
  assign ADDR_ERR  = addr_err_r;
  assign HWR_RI    = hwr_deny; // RQ14
  assign HWENA     = hwena_r;
  assign IRQ       = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_addr_exc;
    EXC.valid && ((EXC.cause == EXC_ADEL) || (EXC.cause == EXC_ADES));
  endsequence

  sequence s_hwena_read;
    REG_RD && (REG_ADDR == OFS_HWENA);
  endsequence

  sequence s_hwena_write;
    REG_WR && (REG_ADDR == OFS_HWENA);
  endsequence

  // A stored word shows two edges later: one to write it, one to read it out
  sequence s_fin_store;
    fin_we && (EXC_CTX == ctx_sel_r) && !(wr_hit && (REG_ADDR == OFS_CTX_SEL));
  endsequence

  sequence s_user_hwr;
    HWR_REQ.valid && HWR_REQ.user_mode;
  endsequence

  a_hwena_reserved : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ3
    s_hwena_read |=> (REG_RDATA & ~HWENA_IMPL) == 32'h00000000)
    else $error("hwena reserved bits not zero");

  a_hwena_reset : assert property (@(posedge REF_CLK) // RQ3
    $past(RESET) |-> hwena_r == HWENA_RESET)
    else $error("hwena not zero after reset");

  a_fvaddr_load : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ4
    s_addr_exc |=> fvaddr_r == $past(EXC.vaddr))
    else $error("fault address not captured");

  a_fvaddr_bus_hold : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ7
    (EXC.valid && (EXC.cause == EXC_BUS_ERR)) |=> $stable(fvaddr_r))
    else $error("bus error changed fault address");

  a_fvaddr_tlb : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ6
    (HAS_TLB && EXC.valid && (EXC.cause == EXC_TLB_MOD)) |=> fvaddr_r == $past(EXC.vaddr))
    else $error("tlb fault address not captured");

  a_addr_err_misalign : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ5
    (ACCESS.valid && (ACCESS.kind != ACC_NONE) && (ACCESS.size_log2 == 2'd2)
     && (ACCESS.vaddr[1:0] != 2'b00)) |=> ADDR_ERR)
    else $error("unaligned access not flagged");

  a_finstr_async : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ9
    (EXC.valid && (EXC.cause <= EXC_DEBUG)) |-> !fin_we)
    else $error("async exception wrote instruction capture");

  a_finstr_short : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ11
    (fin_we && EXC.instr_short) |-> fin_wdata == {HALF_ZERO, EXC.instr[15:0]})
    else $error("short instruction upper half not zero");

  a_config_flag : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ12
    (REG_RD && (REG_ADDR == OFS_CONFIG3)) |=> REG_RDATA[CFG3_FWP_BIT] == HAS_FINST)
    else $error("presence flag wrong");

  a_user_tptr : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ2
    (HWR_REQ.valid && HWR_REQ.user_mode && (HWR_REQ.hwreg == HWREG_TPTR))
    |=> HWR_ALLOW == $past(hwena_r[HWENA_TPTR_BIT]))
    else $error("thread pointer access gate wrong");

  a_mask_gate : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ1 RQ14
    (HWR_REQ.valid && HWR_REQ.user_mode && (HWR_REQ.hwreg == 5'h00) && !hwena_r[0])
    |=> HWR_RI && !HWR_ALLOW)
    else $error("disabled mask bit allowed read");

  // ----------------------------------------------------------------
  // Capture, gate and status checks
  // ----------------------------------------------------------------

  a_hwena_write : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ1 RQ2 RQ3
    s_hwena_write |=> hwena_r == ($past(REG_WDATA) & HWENA_IMPL))
    else $error("enable register write not kept");

  a_fvaddr_idle : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ4 RQ7
    !EXC.valid |=> $stable(fvaddr_r))
    else $error("fault address moved without an exception");

  a_addr_err_kernel : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ5
    (ACCESS.valid && (ACCESS.kind != ACC_NONE) && ACCESS.user_mode && ACCESS.vaddr[31])
    |=> ADDR_ERR)
    else $error("user access to kernel half not flagged");

  a_addr_err_quiet : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ5
    !ACCESS.valid |=> !ADDR_ERR)
    else $error("address error without an access");

  a_finstr_store : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ8 RQ13
    s_fin_store |=> ##1 fin_rdata == $past(fin_wdata, 2))
    else $error("instruction word not stored for its context");

  a_kernel_hwr : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ14
    (HWR_REQ.valid && !HWR_REQ.user_mode) |=> HWR_ALLOW && !HWR_RI)
    else $error("kernel hardware-register read refused");

  a_user_hwr_pair : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ1 RQ14
    s_user_hwr |=> HWR_ALLOW != HWR_RI)
    else $error("user read neither allowed nor refused");

  a_ri_source : assert property (@(posedge REF_CLK) disable iff (RESET) // RQ14
    HWR_RI |-> $past(HWR_REQ.valid) && $past(HWR_REQ.user_mode))
    else $error("refusal without a user request");

  a_stat_set : assert property (@(posedge REF_CLK) disable iff (RESET)
    s_addr_exc |=> stat_r[IRQ_ADDR_ERR])
    else $error("address error status not set");

  a_stat_sticky : assert property (@(posedge REF_CLK) disable iff (RESET)
    (stat_r[IRQ_ADDR_ERR] && !(wr_hit && (REG_ADDR == OFS_IRQ_STAT)))
    |=> stat_r[IRQ_ADDR_ERR])
    else $error("status bit lost without a clear");

  a_rdata_idle : assert property (@(posedge REF_CLK) disable iff (RESET)
    !REG_RD |=> REG_RDATA == 32'h00000000)
    else $error("read data not zero between reads");

endmodule : fcx_fault_capture

// ### hw/fcx_pkg.sv
package fcx_pkg;

  // ----------------------------------------------------------------
  // Register map (word offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_HWENA    = 4'h0;
  localparam logic [3:0] OFS_FVADDR   = 4'h1;
  localparam logic [3:0] OFS_FINSTR   = 4'h2;
  localparam logic [3:0] OFS_CONFIG3  = 4'h3;
  localparam logic [3:0] OFS_TPTR     = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
  localparam logic [3:0] OFS_CTX_SEL  = 4'h7;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          HWENA_MASK_W   = 4;
  localparam int          HWENA_TPTR_BIT = 29;
  localparam logic [31:0] HWENA_IMPL     = 32'h2000000f;
  localparam logic [31:0] HWENA_RESET    = 32'h00000000;
  localparam int          CFG3_FWP_BIT   = 0;
  localparam logic [31:0] TPTR_RESET     = 32'h00000000;
  localparam logic [31:0] FAULT_RESET    = 32'h00000000;
  localparam logic [15:0] HALF_ZERO      = 16'h0000;
  localparam logic [4:0]  HWREG_TPTR     = 5'h1d;
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_ADDR_ERR   = 0;
  localparam int          IRQ_TLB_ERR    = 1;
  localparam int          IRQ_HWR_DENY   = 2;

  // ----------------------------------------------------------------
  // Exception causes from the pipeline
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    EXC_NONE, EXC_INT, EXC_NMI, EXC_MCHECK, EXC_BUS_ERR, EXC_CACHE_ERR,
    EXC_WATCH, EXC_DEBUG, EXC_CPU, EXC_RI, EXC_OVF, EXC_TRAP, EXC_SYS,
    EXC_BP, EXC_FPE, EXC_C2E, EXC_ADEL, EXC_ADES, EXC_TLBL, EXC_TLBS,
    EXC_TLB_INV, EXC_TLB_RI, EXC_TLB_XI, EXC_TLB_MOD
  } fcx_exc_e;

  typedef enum logic [1:0] {
    ACC_NONE, ACC_LOAD, ACC_STORE, ACC_FETCH
  } fcx_acc_e;

  typedef struct packed {
    logic        valid;
    fcx_acc_e    kind;
    logic [31:0] vaddr;
    logic [1:0]  size_log2;
    logic        user_mode;
  } fcx_access_s;

  typedef struct packed {
    logic        valid;
    fcx_exc_e    cause;
    logic [31:0] vaddr;
    logic [31:0] instr;
    logic        instr_valid;
    logic        instr_short;
  } fcx_exc_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] hwreg;
    logic       user_mode;
  } fcx_hwr_s;

  // Unaligned for its size, or user touching the kernel half
  function automatic logic addr_fault(input fcx_access_s a);
    logic mis;
    mis = 1'b0;
    case (a.size_log2)
      2'd1:    mis = a.vaddr[0];
      2'd2:    mis = |a.vaddr[1:0];
      default: mis = 1'b0;
    endcase
    return a.valid && (a.kind != ACC_NONE) && (mis || (a.user_mode && a.vaddr[31]));
  endfunction : addr_fault

  function automatic logic sets_fvaddr(input fcx_exc_e c, input logic has_tlb);
    return (c == EXC_ADEL) || (c == EXC_ADES) ||
      (has_tlb && ((c == EXC_TLBL) || (c == EXC_TLBS) ||
                   (c == EXC_TLB_INV) || (c == EXC_TLB_MOD)));
  endfunction : sets_fvaddr

  function automatic logic sets_finstr(input fcx_exc_e c);
    return (c >= EXC_CPU) && (c <= EXC_TLB_MOD);
  endfunction : sets_finstr

endpackage : fcx_pkg

// ### hw/fcx_ctx_mem.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Per-context capture store, registered read port
// ----------------------------------------------------------------
module fcx_ctx_mem
  import fcx_pkg::*;
#(
  parameter int CTX = 2,
  parameter int AW  = (CTX > 1) ? $clog2(CTX) : 1
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata
);
  logic [31:0] mem [CTX];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : fcx_ctx_mem

// ### hw/fcx_hwr_gate.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Permission check for the hardware-register read instruction
// ----------------------------------------------------------------
module fcx_hwr_gate
  import fcx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire fcx_hwr_s    req,
  input  wire logic [31:0] hwena,
  output logic             allow,
  output logic             deny
);
  logic bit_en;
  logic allow_nxt;
  logic deny_nxt;

  always_comb begin
    bit_en = 1'b0;
    if (req.hwreg == HWREG_TPTR) begin
      bit_en = hwena[HWENA_TPTR_BIT]; // RQ2
    end else if (req.hwreg < 5'(HWENA_MASK_W)) begin
      bit_en = hwena[req.hwreg[1:0]]; // RQ1
    end
    // Kernel always reads; user needs the enable bit
    allow_nxt = req.valid && (!req.user_mode || bit_en); // RQ14
    deny_nxt  = req.valid && req.user_mode && !bit_en; // RQ14
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      allow <= 1'b0;
      deny  <= 1'b0;
    end else begin
      allow <= allow_nxt;
      deny  <= deny_nxt;
    end
  end

  a_deny_user_only : assert property (@(posedge clk) disable iff (rst) // RQ14
    deny |-> $past(req.user_mode) && !allow)
    else $error("hwr deny without user mode");
endmodule : fcx_hwr_gate

// ### tb/fcx_pipe_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Pipeline side: one-cycle requests, scrambled fields once released
// ----------------------------------------------------------------
module fcx_pipe_model
  import fcx_pkg::*;
(
  input  wire logic  clk,
  output fcx_access_s access,
  output fcx_exc_s    exc,
  output logic [0:0]  exc_ctx,
  output fcx_hwr_s    hwr
);
  initial begin
    access  = '0;
    exc     = '0;
    exc_ctx = '0;
    hwr     = '0;
  end

  // Released fields show the inverse so a stale value can never match
  task automatic do_access(input fcx_access_s a);
    fcx_access_s r;
    r       = ~a;
    r.valid = 1'b0;
    @(posedge clk);
    access <= a;
    @(posedge clk);
    access <= r;
  endtask : do_access

  task automatic do_exc(input fcx_exc_s e, input logic [0:0] ctx);
    fcx_exc_s r;
    r       = ~e;
    r.valid = 1'b0;
    @(posedge clk);
    exc     <= e;
    exc_ctx <= ctx;
    @(posedge clk);
    exc     <= r;
    exc_ctx <= ~ctx;
  endtask : do_exc

  task automatic do_hwr(input fcx_hwr_s h);
    fcx_hwr_s r;
    r       = ~h;
    r.valid = 1'b0;
    @(posedge clk);
    hwr <= h;
    @(posedge clk);
    hwr <= r;
  endtask : do_hwr
endmodule : fcx_pipe_model

// ### tb/fcx_fault_capture_bench.sv
`timescale 1ns/100ps
module fcx_fault_capture_bench
  import fcx_pkg::*;
;
  logic        ref_clk;
  logic        reset;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  fcx_access_s access;
  fcx_exc_s    exc;
  logic [0:0]  exc_ctx;
  fcx_hwr_s    hwr_req;
  logic        addr_err;
  logic        hwr_allow;
  logic        hwr_ri;
  logic [31:0] hwena;
  logic        irq;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  integer      seed = 32'h754f36e4;

  fcx_fault_capture #(.CTX(2), .HAS_TLB(1'b1), .HAS_FINST(1'b1)) fcx_fault_capture_i (
    .REF_CLK(ref_clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ACCESS(access),
    .ADDR_ERR(addr_err), .EXC(exc), .EXC_CTX(exc_ctx), .HWR_REQ(hwr_req),
    .HWR_ALLOW(hwr_allow), .HWR_RI(hwr_ri), .HWENA(hwena), .IRQ(irq));

  fcx_pipe_model fcx_pipe_model_i (
    .clk(ref_clk), .access(access), .exc(exc), .exc_ctx(exc_ctx), .hwr(hwr_req));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  function automatic logic exp_fault(input fcx_access_s a);
    logic odd;
    odd = (a.size_log2 == 2'd1) ? a.vaddr[0] : (a.size_log2 == 2'd2) ? |a.vaddr[1:0] : 1'b0;
    return a.valid && (a.kind != ACC_NONE) && (odd || (a.user_mode && a.vaddr[31]));
  endfunction : exp_fault

  initial begin
    logic [31:0] d;
    logic [31:0] ena;
    logic [31:0] fva;
    logic [31:0] fin [2];
    logic        known [2];
    logic [4:0]  regs [6];
    logic        exp;
    fcx_access_s a;
    fcx_exc_s    e;
    fcx_hwr_s    h;
    logic [0:0]  ctx;
    regs      = '{5'h0, 5'h1, 5'h2, 5'h3, 5'h1d, 5'h7};
    known     = '{1'b0, 1'b0};
    reset     = 1'b1;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    reg_read(OFS_HWENA, d);
    check("enable reset", d, 32'h0);
    reg_write(OFS_HWENA, 32'hffffffff);
    reg_read(OFS_HWENA, d);
    check("enable unimpl", d, 32'h2000000f);
    reg_read(OFS_CONFIG3, d);
    check("presence flag", {31'h0, d[0]}, 32'h1);
    reg_read(4'hf, d);
    check("unmapped", d, 32'h0);
    ena = $random(seed);
    reg_write(OFS_TPTR, ena);
    reg_read(OFS_TPTR, d);
    check("thread pointer", d, ena);
    reg_write(OFS_IRQ_MASK, 32'hffffffff);
    reg_read(OFS_IRQ_MASK, d);
    check("irq mask", d, 32'h7);
    $display("Test registers done");
    for (int i = 0; i < 30; i++) begin
      ena = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
      reg_write(OFS_HWENA, ena);
      h.valid     = 1'b1;
      h.hwreg     = regs[i % 6];
      h.user_mode = (i < 12) ? 1'b1 : d[0];
      d           = $random(seed);
      fcx_pipe_model_i.do_hwr(h);
      exp = !h.user_mode || (h.hwreg < 5'h4 && ena[h.hwreg]) || (h.hwreg == 5'h1d && ena[29]);
      #1 check("enable port", hwena, ena & 32'h2000000f);
      check("hwr allow", {31'h0, hwr_allow}, {31'h0, exp});
      check("hwr deny", {31'h0, hwr_ri}, {31'h0, !exp});
    end
    $display("Test hardware-register gate done");
    // A reset in mid-run must clear the enable mask again
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    reg_read(OFS_HWENA, d);
    check("enable re-reset", d, 32'h0);
    check("enable port re-reset", hwena, 32'h0);
    $display("Test mid-run reset done");
    for (int i = 0; i < 40; i++) begin
      d           = $random(seed);
      a.valid     = d[5] | d[6];
      a.kind      = fcx_acc_e'(d[1:0]);
      a.size_log2 = (d[3:2] == 2'd3) ? 2'd2 : d[3:2];
      a.user_mode = d[4];
      a.vaddr     = $random(seed);
      if (i < 2) begin
        a = '{valid: 1'b1, kind: ACC_STORE, vaddr: 32'h80000000, size_log2: 2'd2,
              user_mode: (i == 0)};
      end
      fcx_pipe_model_i.do_access(a);
      #1 check("address fault", {31'h0, addr_err}, {31'h0, exp_fault(a)});
    end
    $display("Test address faults done");
    reg_write(OFS_IRQ_STAT, 32'h7);
    reg_write(OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 48; i++) begin
      d     = $random(seed);
      e     = '0;
      e.valid       = 1'b1;
      e.cause       = (i < 2) ? EXC_ADEL : fcx_exc_e'(5'(1 + (i - 2) % 23));
      e.vaddr       = $random(seed);
      e.instr       = $random(seed);
      e.instr_valid = 1'b1;
      e.instr_short = d[0];
      ctx           = (i < 2) ? 1'(i) : d[1];
      fcx_pipe_model_i.do_exc(e, ctx);
      exp = e.cause inside {EXC_ADEL, EXC_ADES};
      #1 check("irq raised", {31'h0, irq}, {31'h0, exp});
      if (e.cause inside {EXC_ADEL, EXC_ADES, EXC_TLBL, EXC_TLBS, EXC_TLB_INV, EXC_TLB_MOD}) begin
        fva = e.vaddr;
      end
      if (!(e.cause inside {EXC_INT, EXC_NMI, EXC_MCHECK, EXC_BUS_ERR, EXC_CACHE_ERR,
                            EXC_WATCH, EXC_DEBUG})) begin
        fin[ctx]   = e.instr_short ? {16'h0, e.instr[15:0]} : e.instr;
        known[ctx] = 1'b1;
      end
      reg_write(OFS_IRQ_STAT, 32'h7);
      reg_write(OFS_FVADDR, ~fva);
      #1 check("irq cleared", {31'h0, irq}, 32'h0);
      reg_read(OFS_FVADDR, d);
      check("fault address", d, fva);
      for (int k = 0; k < 2; k++) begin
        reg_write(OFS_CTX_SEL, 32'(k));
        reg_read(OFS_FINSTR, d);
        if (known[k]) begin
          check("fault instr", d, fin[k]);
        end
      end
    end
    $display("Test exception capture done");
    give_verdict();
  end
endmodule : fcx_fault_capture_bench
